// ==== core/dac_acq_ctrl.sv ====
// acquisition sequencer, decimation and trigger control
`timescale 1ns/1ps
`include "dac_map.svh"
module dac_acq_ctrl
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // configuration and control
    input  wire dac_pkg::dac_cfg_s cfg_i,
    input  wire logic             start_i,
    input  wire logic             sw_trig_i,
    // converter samples and downconverter results
    input  wire logic [13:0]      adc_data_i,
    input  wire logic [15:0]      ddc_i_i,
    input  wire logic [15:0]      ddc_q_i,
    input  wire logic [15:0]      ddc_phase_i,
    input  wire logic [15:0]      ddc_mag_i,
    input  wire logic             ddc_valid_i,
    // external trigger line
    input  wire logic             ext_trig_i,
    // reference and oscillator status
    input  wire logic             pll_locked_i,
    // memory write port
    output dac_pkg::dac_wr_s      mem_wr_o,
    // downconverter setup
    output logic                  ddc_route_o,
    output logic [14:0]           ddc_dec_o,
    output logic                  ddc_polar_o,
    output logic                  ddc_discrim_o,
    // clocking and conditioning
    output logic [1:0]            ref_sel_o,
    output logic                  dither_o,
    // dma descriptor for the host
    output logic                  dma_start_o,
    output logic [24:0]           dma_addr_o,
    output logic [24:0]           dma_len_o,
    // status
    output logic                  busy_o,
    output logic                  done_o,
    output logic [15:0]           rec_done_o,
    output logic                  trig_armed_o
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    dac_pkg::dac_state_e state_reg;
    logic [15:0] div_reg;
    logic        ext_s1_reg;
    logic        ext_s2_reg;
    logic        ext_s3_reg;
    logic [24:0] base_reg;
    logic [24:0] wptr_reg;
    logic [24:0] pre_reg;
    logic [24:0] post_reg;
    logic [24:0] stored_reg;
    logic [24:0] rec_len_reg;
    logic [24:0] trig_ptr_reg;
    logic [15:0] rec_reg;
    logic [13:0] dead_reg;
    logic        smp_en;
    logic        trig;
    logic [24:0] pre_eff;
    logic [24:0] reg_size;
    logic [31:0] smp_data;
    logic        rec_fin;
    logic        last_fin;

    // enforce the minimum record and pretrigger length
    function automatic logic [24:0] at_least_min(input logic [24:0] v);
        at_least_min = (v < `DAC_MIN_BUF) ? `DAC_MIN_BUF : v;
    endfunction

    // ----------------------------------------------------------------
    // sample selection
    // ----------------------------------------------------------------
    // divider passes one sample of every n at the full rate
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            div_reg <= 16'h0000;
        else if (div_reg + 16'h0001 >= cfg_i.keep_n)
            div_reg <= 16'h0000;
        else
            div_reg <= div_reg + 16'h0001;
    end

    // choose direct or downconverted path
    always_comb
    begin
        if (cfg_i.ddc_en)
        begin
            smp_en   = ddc_valid_i;
            smp_data = cfg_i.polar ? {ddc_phase_i, ddc_mag_i}
                                   : {ddc_i_i, ddc_q_i};
        end
        else
        begin
            smp_en   = (div_reg == 16'h0000);
            smp_data = {18'h00000, adc_data_i};
        end
    end

    // ----------------------------------------------------------------
    // trigger qualification
    // ----------------------------------------------------------------
    // two-stage synchroniser then edge detector on the third stage
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
        end
        else
        begin
            ext_s1_reg <= ext_trig_i;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    // source select; only counted while armed
    assign trig = cfg_i.sw_trig_sel ? sw_trig_i
                : (ext_s2_reg & ~ext_s3_reg);
    assign pre_eff  = at_least_min(cfg_i.pre_cnt);
    assign rec_len_reg = at_least_min(cfg_i.pre_cnt + cfg_i.post_cnt);
    assign reg_size = rec_len_reg;
    // a record ends this cycle, and whether it is the last one
    assign rec_fin  = (state_reg == dac_pkg::DAC_POST)
                   && (post_reg >= cfg_i.post_cnt);
    assign last_fin = rec_fin && (rec_reg + 16'h0001 >= cfg_i.rec_cnt);

    // ----------------------------------------------------------------
    // record sequencer
    // ----------------------------------------------------------------
    // states: collect pretrigger, wait trigger, posttrigger, dead time
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg    <= dac_pkg::DAC_IDLE;
            base_reg     <= 25'h0000000;
            wptr_reg     <= 25'h0000000;
            pre_reg      <= 25'h0000000;
            post_reg     <= 25'h0000000;
            stored_reg   <= 25'h0000000;
            trig_ptr_reg <= 25'h0000000;
            rec_reg      <= 16'h0000;
            dead_reg     <= 14'h0000;
        end
        else
        begin
            case (state_reg)
                dac_pkg::DAC_IDLE:
                    if (start_i && cfg_i.rec_cnt != 16'h0000)
                    begin
                        state_reg <= dac_pkg::DAC_PRE;
                        base_reg  <= 25'h0000000;
                        wptr_reg  <= 25'h0000000;
                        pre_reg   <= 25'h0000000;
                        rec_reg   <= 16'h0000;
                    end
                dac_pkg::DAC_PRE:
                    if (smp_en)
                    begin
                        // circular region of one record length
                        wptr_reg <= (wptr_reg + 25'h0000001 >= reg_size)
                                  ? 25'h0000000
                                  : wptr_reg + 25'h0000001;
                        pre_reg  <= pre_reg + 25'h0000001;
                        if (pre_reg + 25'h0000001 >= pre_eff)
                            state_reg <= dac_pkg::DAC_ARM;
                    end
                dac_pkg::DAC_ARM:
                begin
                    if (trig)
                    begin
                        state_reg    <= dac_pkg::DAC_POST;
                        post_reg     <= 25'h0000000;
                        trig_ptr_reg <= wptr_reg;
                    end
                    if (smp_en)
                        wptr_reg <= (wptr_reg + 25'h0000001 >= reg_size)
                                  ? 25'h0000000
                                  : wptr_reg + 25'h0000001;
                end
                dac_pkg::DAC_POST:
                    if (post_reg >= cfg_i.post_cnt)
                    begin
                        stored_reg <= base_reg;
                        rec_reg    <= rec_reg + 16'h0001;
                        base_reg   <= base_reg + reg_size;
                        wptr_reg   <= 25'h0000000;
                        pre_reg    <= 25'h0000000;
                        dead_reg   <= (reg_size > `DAC_LONG_REC_SMP)
                            ? 14'(`DAC_DEAD_SHORT_CYC)
                            : 14'(`DAC_DEAD_LONG_CYC);
                        state_reg  <= (rec_reg + 16'h0001 >= cfg_i.rec_cnt)
                                    ? dac_pkg::DAC_IDLE
                                    : dac_pkg::DAC_DEAD;
                    end
                    else if (smp_en)
                    begin
                        post_reg <= post_reg + 25'h0000001;
                        wptr_reg <= (wptr_reg + 25'h0000001 >= reg_size)
                                  ? 25'h0000000
                                  : wptr_reg + 25'h0000001;
                    end
                dac_pkg::DAC_DEAD:
                    // triggers ignored while next region is prepared
                    if (dead_reg <= 14'h0001)
                        state_reg <= dac_pkg::DAC_PRE;
                    else
                        dead_reg <= dead_reg - 14'h0001;
                default:
                    state_reg <= dac_pkg::DAC_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // memory writes and dma hand-off
    // ----------------------------------------------------------------
    // write each kept sample into the current region
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            mem_wr_o <= '0;
        else
        begin
            mem_wr_o.valid <= smp_en && (state_reg == dac_pkg::DAC_PRE
                           || state_reg == dac_pkg::DAC_ARM
                           || (state_reg == dac_pkg::DAC_POST
                               && post_reg < cfg_i.post_cnt));
            mem_wr_o.addr  <= base_reg + wptr_reg;
            mem_wr_o.data  <= smp_data;
        end
    end

    // post a dma descriptor per finished record
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dma_start_o <= 1'b0;
            dma_addr_o  <= 25'h0000000;
            dma_len_o   <= 25'h0000000;
        end
        else
        begin
            dma_start_o <= (state_reg == dac_pkg::DAC_POST)
                        && (post_reg >= cfg_i.post_cnt);
            dma_addr_o  <= base_reg;
            dma_len_o   <= (cfg_i.req_len < reg_size)
                         ? cfg_i.req_len : reg_size;
        end
    end

    // ----------------------------------------------------------------
    // static setup outputs and status
    // ----------------------------------------------------------------
    // downconverter, reference and dither settings
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ddc_route_o   <= 1'b0;
            ddc_dec_o     <= `DAC_DEC_MIN;
            ddc_polar_o   <= 1'b0;
            ddc_discrim_o <= 1'b0;
            ref_sel_o     <= `DAC_REF_FRONT;
            dither_o      <= 1'b0;
        end
        else
        begin
            ddc_route_o   <= cfg_i.ddc_en;
            ddc_dec_o     <= (cfg_i.ddc_dec < `DAC_DEC_MIN) ? `DAC_DEC_MIN
                           : (cfg_i.ddc_dec > `DAC_DEC_MAX) ? `DAC_DEC_MAX
                           : cfg_i.ddc_dec;
            ddc_polar_o   <= cfg_i.polar;
            ddc_discrim_o <= cfg_i.discrim;
            ref_sel_o     <= cfg_i.ref_sel;
            dither_o      <= cfg_i.dither_en;
        end
    end

    // status flags
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            busy_o       <= 1'b0;
            done_o       <= 1'b0;
            trig_armed_o <= 1'b0;
            rec_done_o   <= 16'h0000;
        end
        else
        begin
            // done, count and busy change together at the last record
            busy_o       <= (state_reg != dac_pkg::DAC_IDLE) && !last_fin;
            trig_armed_o <= (state_reg == dac_pkg::DAC_ARM);
            rec_done_o   <= rec_fin ? rec_reg + 16'h0001 : rec_reg;
            // a finishing record wins over a start in the same cycle
            if (last_fin)
                done_o <= 1'b1;
            else if (start_i)
                done_o <= 1'b0;
        end
    end

endmodule // dac_acq_ctrl

// ==== core/dac_map.svh ====
// constants and rule summary for the digitizer acquisition control block
// Function
// - keep one sample in every n
// - optional downconverter path before memory
// - quadrature mix then decimate by 4..16384
// - output iq or phase/magnitude, optional discriminator
// - store at least 256 samples per record
// - transfer only requested count to host
// - pretrigger writes circular, overwrite until trigger
// - store posttrigger count then end record
// - counts limited only by memory size
// - each trigger completes one further record
// - dead time between records ignores triggers
// - long records: 500 ns dead time
// - short records: 80 us dead time
// - refuse triggers until minimum pretrigger collected
// - trigger source external line or software
// - lock clock to front or backplane reference
// - free-running clock option
// - sample clock from 64 MHz oscillator
// - dither off until software enables it
// - dma moves stored samples to host
`ifndef DAC_MAP_SVH
`define DAC_MAP_SVH
// ----------------------------------------------------------------
// widths and figures
// ----------------------------------------------------------------
`define DAC_SAMPLE_W      14
`define DAC_ADDR_W        25
`define DAC_MEM_SAMPLES   26'h2000000
`define DAC_MIN_BUF       25'h0000100
`define DAC_DEC_MIN       15'h0004
`define DAC_DEC_MAX       15'h4000
`define DAC_CLK_MHZ       100
`define DAC_FULL_RATE_MHZ 64
`define DAC_REF_MHZ       10
`define DAC_LONG_REC_US   80
`define DAC_DEAD_SHORT_NS 500
`define DAC_DEAD_LONG_US  80
`define DAC_DEAD_SHORT_CYC (`DAC_DEAD_SHORT_NS * `DAC_CLK_MHZ / 1000)
`define DAC_DEAD_LONG_CYC  (`DAC_DEAD_LONG_US * `DAC_CLK_MHZ)
`define DAC_LONG_REC_SMP   (`DAC_LONG_REC_US * `DAC_FULL_RATE_MHZ)
// reference selection codes
`define DAC_REF_FRONT     2'h0
`define DAC_REF_BACKPLANE 2'h1
`define DAC_REF_FREE      2'h2
`endif

// ==== core/dac_pkg.sv ====
// types for the digitizer acquisition control block
package dac_pkg;
    // acquisition sequencer states
    typedef enum logic [4:0] {
        DAC_IDLE = 5'h01,
        DAC_PRE  = 5'h02,
        DAC_ARM  = 5'h04,
        DAC_POST = 5'h08,
        DAC_DEAD = 5'h10
    } dac_state_e;
    // configuration held by the host before start
    typedef struct packed {
        logic [15:0] keep_n;
        logic        ddc_en;
        logic [14:0] ddc_dec;
        logic        polar;
        logic        discrim;
        logic [24:0] pre_cnt;
        logic [24:0] post_cnt;
        logic [15:0] rec_cnt;
        logic [24:0] req_len;
        logic        sw_trig_sel;
        logic [1:0]  ref_sel;
        logic        dither_en;
    } dac_cfg_s;
    // one memory write
    typedef struct packed {
        logic        valid;
        logic [24:0] addr;
        logic [31:0] data;
    } dac_wr_s;
endpackage

// ==== bench/dac_acq_chk.sv ====
// port checker for the acquisition control block
`timescale 1ns/1ps
module dac_acq_chk
(
    // clock and reset
    input wire logic              clk_i,
    input wire logic              rst_i,
    // inputs watched
    input wire dac_pkg::dac_cfg_s cfg_i,
    input wire logic              start_i,
    input wire logic              sw_trig_i,
    input wire logic              ext_trig_i,
    // outputs watched
    input wire logic [14:0]       ddc_dec_o,
    input wire logic              dither_o,
    input wire logic              dma_start_o,
    input wire logic [24:0]       dma_len_o,
    input wire logic              busy_o,
    input wire logic              done_o,
    input wire logic [15:0]       rec_done_o,
    input wire logic              trig_armed_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] gap_reg;
    logic        after_reg;
    logic        short_w;
    // cycles since the last finished record
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            gap_reg <= 16'h0000;
        else if (dma_start_o)
            gap_reg <= 16'h0000;
        else if (gap_reg != 16'hFFFF)
            gap_reg <= gap_reg + 16'h0001;
    end
    // a record has ended since the last start
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            after_reg <= 1'b0;
        else if (start_i)
            after_reg <= 1'b0;
        else if (dma_start_o)
            after_reg <= 1'b1;
    end
    // record of at most 80 us at full rate
    assign short_w = ({1'b0, cfg_i.pre_cnt} + {1'b0, cfg_i.post_cnt})
                     <= 26'h0001400;
    dither_off_a: assert property (!cfg_i.dither_en [*2] |-> !dither_o)
        else $error("dither on without request");
    dec_range_a: assert property (ddc_dec_o >= 15'h0004 && ddc_dec_o <= 15'h4000)
        else $error("decimation out of range");
    dma_len_a: assert property (dma_start_o && cfg_i.req_len < 25'h0000100
        |-> dma_len_o == cfg_i.req_len) else $error("dma length not requested");
    sw_take_a: assert property (trig_armed_o && cfg_i.sw_trig_sel && sw_trig_i
        |-> ##[1:3] !trig_armed_o) else $error("software trigger not taken");
    ext_sync_a: assert property (trig_armed_o && !cfg_i.sw_trig_sel
        && $rose(ext_trig_i) |-> trig_armed_o [*2] ##[1:4] !trig_armed_o)
        else $error("external edge timing wrong");
    dead_hold_a: assert property (dma_start_o |-> !trig_armed_o [*5])
        else $error("armed during dead time");
    short_dead_a: assert property (after_reg && short_w && $rose(trig_armed_o)
        |-> gap_reg >= 16'h1F40) else $error("short record dead time too small");
    done_cnt_a: assert property ($rose(done_o)
        |-> rec_done_o == cfg_i.rec_cnt && !busy_o) else $error("record count wrong");
endmodule // dac_acq_chk

// ==== bench/dac_host_model.sv ====
// host model: takes dma descriptors and tallies words pulled
`timescale 1ns/1ps
module dac_host_model
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // dma descriptor from the device
    input  wire logic        dma_start_i,
    input  wire logic [24:0] dma_len_i,
    // tallies
    output logic [15:0]      dma_cnt_o,
    output logic [31:0]      rd_words_o
);
    // pull only the stated length of each record
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            dma_cnt_o  <= 16'h0000;
            rd_words_o <= 32'h00000000;
        end
        else if (dma_start_i)
        begin
            dma_cnt_o  <= dma_cnt_o + 16'h0001;
            rd_words_o <= rd_words_o + {7'h00, dma_len_i};
        end
    end
endmodule // dac_host_model

// ==== bench/digitizer_acquisition_control_tb.sv ====
// self-checking bench for the acquisition control block
`timescale 1ns/1ps
module digitizer_acquisition_control_tb;
    localparam logic [14:0] DEC [4] = '{15'h0002, 15'h0064, 15'h4000, 15'h7FFF};
    localparam logic [14:0] DEXP [4] = '{15'h0004, 15'h0064, 15'h4000, 15'h4000};
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    dac_pkg::dac_cfg_s cfg_i = '0;
    logic              start_i = 1'b0;
    logic              sw_trig_i = 1'b0;
    logic              ext_trig_i = 1'b0;
    logic              ddc_valid_i = 1'b0;
    logic              ddc_on = 1'b0;
    logic [13:0]       adc_w = 14'h1ABC;
    logic [15:0]       ddc_w = 16'h1234;
    dac_pkg::dac_wr_s  mem_wr_o;
    logic              ddc_route_o, ddc_polar_o, ddc_discrim_o, dither_o;
    logic              dma_start_o, busy_o, done_o, trig_armed_o;
    logic [14:0]       ddc_dec_o;
    logic [1:0]        ref_sel_o;
    logic [24:0]       dma_addr_o, dma_len_o;
    logic [15:0]       rec_done_o, dma_cnt;
    logic [31:0]       rd_words;
    logic [31:0]       cyc = 32'h00000000;
    logic [24:0]       last_a = 25'h0000000;
    int                num_errors = 0;
    int                checks = 0;
    dac_acq_ctrl dut_u
    (
        .clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg_i), .start_i(start_i),
        .sw_trig_i(sw_trig_i), .adc_data_i(adc_w), .ddc_i_i(ddc_w),
        .ddc_q_i(~ddc_w), .ddc_phase_i({ddc_w[7:0], ddc_w[15:8]}),
        .ddc_mag_i(ddc_w ^ 16'h5A5A), .ddc_valid_i(ddc_valid_i),
        .ext_trig_i(ext_trig_i), .pll_locked_i(1'b1), .mem_wr_o(mem_wr_o),
        .ddc_route_o(ddc_route_o), .ddc_dec_o(ddc_dec_o),
        .ddc_polar_o(ddc_polar_o), .ddc_discrim_o(ddc_discrim_o),
        .ref_sel_o(ref_sel_o), .dither_o(dither_o),
        .dma_start_o(dma_start_o), .dma_addr_o(dma_addr_o),
        .dma_len_o(dma_len_o), .busy_o(busy_o), .done_o(done_o),
        .rec_done_o(rec_done_o), .trig_armed_o(trig_armed_o)
    );
    dac_host_model host_u
    (
        .clk_i(clk_i), .rst_i(rst_i), .dma_start_i(dma_start_o),
        .dma_len_i(dma_len_o), .dma_cnt_o(dma_cnt), .rd_words_o(rd_words)
    );
    // clock, downconverter result strobe and hang limit
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc <= cyc + 32'h00000001;
        ddc_valid_i <= ddc_on & (cyc[1:0] == 2'h0);
        if (cyc == 32'h00009C40)
        begin
            num_errors++;
            end_of_test;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // program a run and start it
    task automatic acq(input logic [15:0] n, input logic [24:0] pre,
        input logic [24:0] post, input logic [15:0] recs,
        input logic [24:0] req, input logic sw, input logic ddc);
        @(posedge clk_i);
        cfg_i.keep_n <= n;
        cfg_i.pre_cnt <= pre;
        cfg_i.post_cnt <= post;
        cfg_i.rec_cnt <= recs;
        cfg_i.req_len <= req;
        cfg_i.sw_trig_sel <= sw;
        cfg_i.ddc_en <= ddc;
        ddc_on <= ddc;
        @(posedge clk_i);
        start_i <= 1'b1;
        tick(1);
        start_i <= 1'b0;
    endtask
    // external pulse held ten cycles, software pulse one
    task automatic fire(input logic sw);
        @(posedge clk_i);
        sw_trig_i <= sw;
        ext_trig_i <= !sw;
        @(posedge clk_i);
        sw_trig_i <= 1'b0;
        if (!sw) repeat (9) @(posedge clk_i);
        ext_trig_i <= 1'b0;
        #1;
    endtask
    // wait for arming or record end, counting writes
    task automatic wait_for(input bit dma, output int w, output int c,
        output logic [31:0] d);
        w = 0;
        c = 0;
        d = '0;
        while (c < 20000 && (dma ? dma_start_o : trig_armed_o) !== 1'b1)
        begin
            tick(1);
            c++;
            if (mem_wr_o.valid === 1'b1 && (dma || trig_armed_o !== 1'b1))
            begin
                w++;
                d = mem_wr_o.data;
                last_a = mem_wr_o.addr;
            end
        end
    endtask
    //--------------------------------------------------------------
    // tests
    //--------------------------------------------------------------
    initial
    begin : main
        int w, c;
        logic [31:0] d;
        tick(20);
        chk("dec at reset", 32'h4, 32'(ddc_dec_o));
        chk("dither at reset", 32'h0, 32'(dither_o));
        @(posedge clk_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk_i);
            cfg_i.ddc_dec <= DEC[k];
            cfg_i.ref_sel <= 2'(k % 3);
            cfg_i.ddc_en <= k[0];
            cfg_i.polar <= k[1];
            cfg_i.discrim <= k[0];
            cfg_i.dither_en <= k[1];
            tick(2);
            chk("dec", 32'(DEXP[k]), 32'(ddc_dec_o));
            chk("ref", 32'(k % 3), 32'(ref_sel_o));
            chk("route", 32'(k[0]), 32'(ddc_route_o));
            chk("polar", 32'(k[1]), 32'(ddc_polar_o));
            chk("discrim", 32'(k[0]), 32'(ddc_discrim_o));
            chk("dither", 32'(k[1]), 32'(dither_o));
        end
        $display("test setup copies done");
        @(posedge clk_i);
        cfg_i <= '0;
        acq(16'h1, 25'h0A, 25'h14, 16'h2, 25'h8, 1'b1, 1'b0);
        wait_for(0, w, c, d);
        chk("pre writes", 32'h100, 32'(w));
        fire(1'b1);
        wait_for(1, w, c, d);
        chk("post writes", 32'h14, 32'(w));
        chk("dma len", 32'h8, 32'(dma_len_o));
        chk("dma base", 32'h0, 32'(dma_addr_o));
        chk("last addr", 32'h16, 32'(last_a));
        fire(1'b1);
        wait_for(0, w, c, d);
        chk("short dead", 32'h1, 32'(c >= 7990 && c < 8400));
        fire(1'b1);
        wait_for(1, w, c, d);
        chk("dma base", 32'h100, 32'(dma_addr_o));
        chk("last addr", 32'h116, 32'(last_a));
        tick(2);
        chk("done", 32'h1, 32'(done_o));
        chk("records", 32'h2, 32'(rec_done_o));
        chk("dma seen", 32'h2, 32'(dma_cnt));
        chk("host words", 32'h10, rd_words);
        $display("test short records done");
        acq(16'h1, 25'h1450, 25'h4, 16'h2, 25'h1454, 1'b0, 1'b0);
        fire(1'b0);
        wait_for(0, w, c, d);
        chk("early refused", 32'h0, 32'(rec_done_o));
        fire(1'b1);
        tick(2);
        chk("other source", 32'h1, 32'(trig_armed_o));
        // the pulse outlasts a short posttrigger, so the record ends inside
        fire(1'b0);
        chk("long first", 32'h1, 32'(rec_done_o));
        fire(1'b0);
        wait_for(0, w, c, d);
        chk("long dead", 32'h1, 32'(c < 5300));
        fire(1'b0);
        tick(2);
        chk("long done", 32'h1, 32'(done_o));
        chk("long records", 32'h2, 32'(rec_done_o));
        chk("long dma", 32'h4, 32'(dma_cnt));
        chk("long words", 32'h28B8, rd_words);
        $display("test long records done");
        acq(16'h4, 25'h0A, 25'h4, 16'h1, 25'h100, 1'b1, 1'b0);
        wait_for(0, w, c, d);
        chk("kept", 32'h100, 32'(w));
        chk("span", 32'h1, 32'(c >= 1015 && c < 1040));
        chk("raw data", 32'h1ABC, {18'h0, d[13:0]});
        fire(1'b1);
        wait_for(1, w, c, d);
        for (int p = 0; p < 2; p++)
        begin
            @(posedge clk_i);
            cfg_i.polar <= p[0];
            acq(16'h1, 25'h0A, 25'h4, 16'h1, 25'h100, 1'b1, 1'b1);
            wait_for(0, w, c, d);
            chk("ddc data", p ? 32'h3412486E : 32'h1234EDCB, d);
            fire(1'b1);
            wait_for(1, w, c, d);
        end
        $display("test decimation and paths done");
        end_of_test;
    end
endmodule // digitizer_acquisition_control_tb
bind dac_acq_ctrl dac_acq_chk chk_u
(
    .clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg_i), .start_i(start_i),
    .sw_trig_i(sw_trig_i), .ext_trig_i(ext_trig_i), .ddc_dec_o(ddc_dec_o),
    .dither_o(dither_o), .dma_start_o(dma_start_o), .dma_len_o(dma_len_o),
    .busy_o(busy_o), .done_o(done_o), .rec_done_o(rec_done_o),
    .trig_armed_o(trig_armed_o)
);
